// ---- hw/spi_port_regs.svh ----
/*
 * constants of the half duplex spi slave port: timing, widths, idle values.
 * assumes a 100 MHz core clock; included by the package and the port module.
 */
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define RESP_TIMEOUT_MS 500
`define RESP_TIMEOUT_CYCLES (`RESP_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define TMO_W 26

// ----------------------------------------
// byte layout and idle values
// ----------------------------------------
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define IDLE_BYTE 8'h00
`define FRAME_SYNC 8'hAA
`define FRAME_TERM 8'h00

`endif

// ---- hw/spi_port_pkg.sv ----
/*
 * types of the half duplex spi slave port.
 * assumes spi_port_regs.svh is on the include path.
 */
`include "spi_port_regs.svh"

package spi_port_pkg;

    typedef enum logic [0:0] {ST_RX, ST_TX} port_mode_t;

    typedef struct packed {
        port_mode_t state;
        logic rs_m;
        logic rs_s;
        logic rs_d;
        logic sclk_m;
        logic sclk_s;
        logic sclk_d;
        logic ssn_m;
        logic ssn_s;
        logic mosi_m;
        logic mosi_s;
        logic [`BIT_CNT_W-1:0] bit_cnt;
        logic [`BYTE_W-1:0] rx_sh;
        logic [`BYTE_W-1:0] rx_data;
        logic rx_valid;
        logic [`BYTE_W-1:0] sh_tx;
        logic cur_valid;
        logic cur_last;
        logic [`BYTE_W-1:0] buf_data;
        logic buf_full;
        logic buf_last;
        logic last_taken;
        logic resp_ready;
        logic miso;
        logic miso_oe;
        logic [`TMO_W-1:0] tmo;
    } port_state_t;

endpackage : spi_port_pkg

// ---- hw/half_duplex_spi_slave_port.sv ----
/*
 * half duplex spi slave port, mode 0, byte wide, with resync pin and
 * response timeout. assumes pins arrive asynchronously and that the user
 * side runs on clk_i and hands response bytes over valid/ready.
 */
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module half_duplex_spi_slave_port #(
    parameter int unsigned TIMEOUT_CYCLES = `RESP_TIMEOUT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic port_select_n_i,
    input wire logic mosi_i,
    input wire logic resync_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [`BYTE_W-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic [`BYTE_W-1:0] resp_data_i,
    input wire logic resp_valid_i,
    input wire logic resp_last_i,
    output logic resp_ready_o,
    output logic busy_o
);

    localparam logic [`TMO_W-1:0] TMO_LAST = `TMO_W'(TIMEOUT_CYCLES - 1);

    spi_port_pkg::port_state_t q;
    spi_port_pkg::port_state_t d;

    logic sclk_rise;
    logic sclk_fall;
    logic resync_rise;
    logic take;

    // ----------------------------------------
    // flush of response state
    // ----------------------------------------
    function automatic spi_port_pkg::port_state_t flush_resp(
        input spi_port_pkg::port_state_t s
    );
        spi_port_pkg::port_state_t r;
        r = s;
        r.state = spi_port_pkg::ST_RX;
        r.buf_full = 1'b0;
        r.buf_last = 1'b0;
        r.cur_valid = 1'b0;
        r.cur_last = 1'b0;
        r.last_taken = 1'b0;
        r.sh_tx = `IDLE_BYTE;
        r.tmo = '0;
        return r;
    endfunction : flush_resp

    assign sclk_rise = q.sclk_s & ~q.sclk_d;
    assign sclk_fall = ~q.sclk_s & q.sclk_d;
    assign resync_rise = q.rs_s & ~q.rs_d;
    assign take = resp_valid_i & q.resp_ready;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.rx_valid = 1'b0;
        d.rs_m = resync_i;
        d.rs_s = q.rs_m;
        d.rs_d = q.rs_s;
        d.sclk_m = sclk_i;
        d.sclk_s = q.sclk_m;
        d.sclk_d = q.sclk_s;
        d.ssn_m = port_select_n_i;
        d.ssn_s = q.ssn_m;
        d.mosi_m = mosi_i;
        d.mosi_s = q.mosi_m;
        if (take)
        begin
            d.buf_data = resp_data_i;
            d.buf_full = 1'b1;
            d.buf_last = resp_last_i;
            d.last_taken = resp_last_i;
        end
        if (q.ssn_s)
        begin
            d.bit_cnt = '0;
        end
        else if (sclk_rise)
        begin
            d.rx_sh = {q.rx_sh[`BYTE_W-2:0], q.mosi_s};
            d.bit_cnt = q.bit_cnt + `BIT_CNT_W'(1);
            if (q.bit_cnt == `BIT_LAST)
            begin
                // no stale bit leaks into a byte with nothing loaded
                d.sh_tx = `IDLE_BYTE;
                if (q.state == spi_port_pkg::ST_RX)
                begin
                    d.rx_data = {q.rx_sh[`BYTE_W-2:0], q.mosi_s};
                    d.rx_valid = 1'b1;
                end
                else if (q.cur_valid)
                begin
                    d.cur_valid = 1'b0;
                    if (q.cur_last)
                    begin
                        d.state = spi_port_pkg::ST_RX;
                        d.last_taken = 1'b0;
                        d.sh_tx = `IDLE_BYTE;
                        d.tmo = '0;
                    end
                end
            end
        end
        else if (sclk_fall && q.bit_cnt != '0)
        begin
            d.sh_tx = {q.sh_tx[`BYTE_W-2:0], 1'b0};
        end
        // load next response byte on a byte boundary while sclk rests low
        if (q.buf_full && !d.cur_valid && d.bit_cnt == '0 && !q.sclk_s)
        begin
            if (d.state == spi_port_pkg::ST_RX)
            begin
                d.state = spi_port_pkg::ST_TX;
                d.tmo = '0;
            end
            d.sh_tx = q.buf_data;
            d.cur_valid = 1'b1;
            d.cur_last = q.buf_last;
            d.buf_full = 1'b0;
        end
        if (q.state == spi_port_pkg::ST_TX && d.state == spi_port_pkg::ST_TX)
        begin
            if (q.tmo == TMO_LAST)
            begin
                d = flush_resp(d);
            end
            else
            begin
                d.tmo = q.tmo + `TMO_W'(1);
            end
        end
        if (resync_rise)
        begin
            d = flush_resp(d);
            d.bit_cnt = '0;
            d.rx_sh = '0;
        end
        d.resp_ready = ~d.buf_full & ~d.last_taken;
        d.miso = d.sh_tx[`BYTE_W-1];
        d.miso_oe = ~q.ssn_s;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '{state: spi_port_pkg::ST_RX, ssn_m: 1'b1, ssn_s: 1'b1, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign miso_o = q.miso;
    assign miso_oe_o = q.miso_oe;
    assign rx_data_o = q.rx_data;
    assign rx_valid_o = q.rx_valid;
    assign resp_ready_o = q.resp_ready;
    assign busy_o = (q.state == spi_port_pkg::ST_TX);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_last_bit;
        sclk_rise && !q.ssn_s && q.bit_cnt == `BIT_LAST && !resync_rise;
    endsequence

    sequence s_tx_mode;
        q.state == spi_port_pkg::ST_TX;
    endsequence

    sequence s_last_resp_byte;
        q.state == spi_port_pkg::ST_TX && q.cur_valid && q.cur_last;
    endsequence

    a_select_high_count: assert property (q.ssn_s |=> q.bit_cnt == '0)
        else $error("bit counter not held at zero while deselected");
    a_resync_clears_port: assert property (resync_rise |=>
        q.state == spi_port_pkg::ST_RX && !q.buf_full && !q.cur_valid && q.bit_cnt == '0)
        else $error("resync edge did not clear port");
    a_resync_two_flops: assert property (resync_rise |-> $past(resync_i, 2))
        else $error("resync edge seen without synchronised input");
    a_rx_sends_zero: assert property (q.state == spi_port_pkg::ST_RX |-> q.sh_tx == `IDLE_BYTE)
        else $error("non zero byte shifted while receiving");
    a_tx_discards_rx: assert property (s_tx_mode and s_last_bit |=> !rx_valid_o)
        else $error("byte passed on during response");
    a_last_then_idle: assert property (s_last_resp_byte and s_last_bit |=>
        q.state == spi_port_pkg::ST_RX ##1 q.sh_tx == `IDLE_BYTE)
        else $error("port did not return to zero bytes after response");
    a_timeout_flush: assert property (q.state == spi_port_pkg::ST_TX && q.tmo == TMO_LAST |=>
        q.state == spi_port_pkg::ST_RX && !q.buf_full && !q.cur_valid)
        else $error("pending response not flushed at timeout");
    a_mosi_on_rise: assert property (sclk_rise && !q.ssn_s && !resync_rise |=>
        q.rx_sh[0] == $past(q.mosi_s))
        else $error("mosi not captured on sclk rise");

endmodule : half_duplex_spi_slave_port

// ---- verification/spi_host_model.sv ----
/*
 * host spi master model: mode 0, msb first, bit-level tasks.
 * assumes the port samples these pins with its own clock.
 */
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk_o,
    output logic sel_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial
    begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    // select level; released mosi shows the inverse of its last value
    task sel(input logic lvl);
        #80 sel_n_o = lvl;
        if (lvl)
            mosi_o = ~mosi_o;
        #80;
    endtask : sel
    // n clock pulses, eight for a whole byte; clock rests low after
    task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            mosi_o = tx[i];
            #80 sclk_o = 1'b1;
            rx[i] = miso_i;
            #80 sclk_o = 1'b0;
        end
        #80 mosi_o = ~mosi_o;
    endtask : xfer
endmodule : spi_host_model

// ---- verification/tb_half_duplex_spi_slave_port.sv ----
/*
 * self-checking bench of the half duplex spi slave port.
 * assumes the host model drives the spi pins and the bench resync and the user side.
 */
`timescale 1ns/1ps
module tb_half_duplex_spi_slave_port;
    localparam int TMO = 2000;
    logic clk, rst_b, resync, miso, miso_oe, rx_valid, sclk, sel_n, mosi;
    logic resp_valid, resp_last, resp_ready, busy;
    logic [7:0] rx_data, resp_data, got;
    logic [7:0] rxq[$];
    logic [7:0] rsp[4] = '{8'hAA, 8'h02, 8'h5A, 8'h00};
    int n_fail, samples_checked;
    half_duplex_spi_slave_port #(.TIMEOUT_CYCLES(TMO)) dut (.clk_i(clk), .rst_b_i(rst_b),
        .sclk_i(sclk), .port_select_n_i(sel_n), .mosi_i(mosi), .resync_i(resync),
        .miso_o(miso), .miso_oe_o(miso_oe), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .resp_data_i(resp_data), .resp_valid_i(resp_valid), .resp_last_i(resp_last),
        .resp_ready_o(resp_ready), .busy_o(busy));
    spi_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task test_done;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task feed(input logic [7:0] d, input logic l);
        @(posedge clk);
        #1 resp_valid = 1'b1;
        resp_data = d;
        resp_last = l;
        @(posedge clk);
        while (resp_ready !== 1'b1)
            @(posedge clk);
        #1 resp_valid = 1'b0;
    endtask : feed
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task s_cmd;
        host.sel(1'b0);
        chk({7'h00, miso_oe}, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            host.xfer(rsp[i], 8, got);
            chk(got, 8'h00);
        end
        host.sel(1'b1);
        chk({7'h00, miso_oe}, 8'h00);
        for (int i = 0; i < 3; i++)
            chk(rxq.pop_front(), rsp[i]);
    endtask : s_cmd
    task s_resp;
        host.sel(1'b0);
        feed(rsp[0], 1'b0);
        repeat (10) @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h01);
        fork
            for (int i = 1; i < 4; i++)
                feed(rsp[i], i == 3);
            for (int i = 0; i < 4; i++)
            begin
                host.xfer(8'h00, 8, got);
                chk(got, rsp[i]);
            end
        join
        for (int i = 0; i < 2; i++)
        begin
            host.xfer(8'hC5, 8, got);
            chk(got, 8'h00);
        end
        host.sel(1'b1);
        chk(8'(rxq.size()), 8'h02);
        for (int i = 0; i < 2; i++)
            chk(rxq.pop_front(), 8'hC5);
        chk({7'h00, busy}, 8'h00);
    endtask : s_resp
    task s_tmo;
        feed(8'hAA, 1'b1);
        repeat (20) @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h01);
        repeat (TMO + 20) @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h00);
        host.sel(1'b0);
        host.xfer(8'h5A, 8, got);
        host.sel(1'b1);
        chk(got, 8'h00);
        chk(rxq.pop_front(), 8'h5A);
    endtask : s_tmo
    task s_sync;
        host.sel(1'b0);
        host.xfer(8'hFF, 3, got);
        #1 resync = 1'b1;
        repeat (10) @(posedge clk);
        #1 resync = 1'b0;
        host.xfer(8'h3C, 8, got);
        host.sel(1'b1);
        chk(rxq.pop_front(), 8'h3C);
        host.sel(1'b0);
        host.xfer(8'hFF, 5, got);
        host.sel(1'b1);
        host.sel(1'b0);
        host.xfer(8'hC3, 8, got);
        host.sel(1'b1);
        chk(rxq.pop_front(), 8'hC3);
        chk(8'(rxq.size()), 8'h00);
    endtask : s_sync
    initial
    begin
        #500000;
        n_fail++;
        test_done();
    end
    initial
    begin
        rst_b = 1'b0;
        resync = 1'b0;
        resp_valid = 1'b0;
        resp_last = 1'b0;
        resp_data = 8'h00;
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, resp_ready}, 8'h01);
        s_cmd();
        s_resp();
        s_tmo();
        s_sync();
        test_done();
    end
endmodule : tb_half_duplex_spi_slave_port
